// File: hdl/pdcap_descriptor.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pdcap_params.svh"

// Behaviour
// R1: byte 1 of the entry holds the device capability descriptor type constant.
// R2: byte 3, the reserved byte after the capability type, always reads as zero.
// R3: bytes 4 to 7 form a 32-bit attribute bitmap where one means supported, zero absent.
// R4: attribute bit 0 is reserved and always reads zero.
// R5: attribute bit 1 is one when battery charging is supported.
// R6: attribute bit 2 is one when power delivery is supported.
// R7: attribute bit 3 is one when the device can supply power; the host heeds it only with bit 2.
// R8: attribute bit 4 is one when the device consumes power; the host heeds it only with bit 2.
// R9: attribute bit 5 is one when the charging policy feature is supported, independent of others.
// R10: attribute bit 6 is one when Type-C current power capabilities are supported.
// R11: byte 2, the capability type, carries the power delivery capability code.
// R12: attribute bit 7 and the upper reserved bits always read zero.
// R13: bytes are served in field order, multi-byte fields least significant byte first.
module pdcap_descriptor
  import pdcap_pkg::*;
#(
  parameter logic [7:0] DESC_TYPE = 8'h10
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        descReq,
  input  wire logic [2:0]  descIdx,
  output logic      [7:0]  descByte,
  output logic             descValid
);

  pdcap_state_t stateQ;
  pdcap_state_t stateD;
  logic [31:0]  attrWord;
  logic         busReq;
  logic         busAccept;

  // one function serves the byte stream; the register view takes attrWord directly
  function automatic logic [7:0] pick_byte(input logic [2:0] idx, input logic [31:0] attr);
    logic [7:0] b;
    b = `PDCAP_BYTE_RST;
    case (idx)
      `PDCAP_IDX_LENGTH:  b = `PDCAP_LENGTH;
      `PDCAP_IDX_TYPE:    b = DESC_TYPE;                           // [R1]
      `PDCAP_IDX_CAPTYPE: b = `PDCAP_CAP_CODE;                     // [R11]
      `PDCAP_IDX_RSVD:    b = `PDCAP_RSVD_BYTE;                    // [R2]
      `PDCAP_IDX_ATTR0:   b = attr[7:0];                           // [R13]
      `PDCAP_IDX_ATTR1:   b = attr[15:8];                          // [R13]
      `PDCAP_IDX_ATTR2:   b = attr[23:16];                         // [R13]
      `PDCAP_IDX_ATTR3:   b = attr[31:24];                         // [R13]
      default:            b = `PDCAP_BYTE_RST;
    endcase
    return b;
  endfunction

  // attribute bitmap: only the software-held features reach it, all else is zero
  always_comb begin
    attrWord = `PDCAP_WORD_ZERO;                                   // [R3] [R4] [R12]
    attrWord[`PDCAP_BIT_BATCHG]   = stateQ.features[`PDCAP_BIT_BATCHG];   // [R5]
    attrWord[`PDCAP_BIT_PD]       = stateQ.features[`PDCAP_BIT_PD];       // [R6]
    attrWord[`PDCAP_BIT_PROVIDER] = stateQ.features[`PDCAP_BIT_PROVIDER]; // [R7]
    attrWord[`PDCAP_BIT_CONSUMER] = stateQ.features[`PDCAP_BIT_CONSUMER]; // [R8]
    attrWord[`PDCAP_BIT_CHGPOL]   = stateQ.features[`PDCAP_BIT_CHGPOL];   // [R9]
    attrWord[`PDCAP_BIT_TYPEC]    = stateQ.features[`PDCAP_BIT_TYPEC];    // [R10]
  end

  // every access waits exactly one cycle so that readdata comes from a flop
  assign busReq      = read | write;
  assign waitrequest = busReq & (stateQ.busState == PDCAP_IDLE);
  assign busAccept   = busReq & (stateQ.busState == PDCAP_ACK);

  always_comb begin
    stateD           = stateQ;
    stateD.descValid = 1'b0;
    case (stateQ.busState)
      PDCAP_IDLE: begin
        if (busReq) begin
          stateD.busState = PDCAP_ACK;
          case (address)
            `PDCAP_REG_CTRL:   stateD.readData = {25'h0000000, stateQ.features, 1'b0};
            `PDCAP_REG_ATTR:   stateD.readData = attrWord;
            `PDCAP_REG_SERVED: stateD.readData = {16'h0000, stateQ.served};
            default:           stateD.readData = `PDCAP_WORD_ZERO;
          endcase
        end
      end
      PDCAP_ACK: begin
        stateD.busState = PDCAP_IDLE;
        // bit 0 is not writable, so the reserved position can never be set
        if (busAccept && write && byteenable[0] && address == `PDCAP_REG_CTRL) begin
          stateD.features = writedata[`PDCAP_FEAT_HI:`PDCAP_FEAT_LO];
        end
      end
      default: stateD.busState = PDCAP_IDLE;
    endcase
    if (descReq) begin
      stateD.descByte  = pick_byte(descIdx, attrWord);
      stateD.descValid = 1'b1;
      stateD.served    = 16'(stateQ.served + 16'h0001);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stateQ.busState  <= PDCAP_IDLE;
      stateQ.readData  <= `PDCAP_WORD_ZERO;
      stateQ.features  <= `PDCAP_CTRL_RST;
      stateQ.descByte  <= `PDCAP_BYTE_RST;
      stateQ.descValid <= 1'b0;
      stateQ.served    <= `PDCAP_SERVED_RST;
    end else begin
      stateQ <= stateD;
    end
  end

  assign readdata  = stateQ.readData;
  assign descByte  = stateQ.descByte;
  assign descValid = stateQ.descValid;

  sequence s_ctrl_write;
    write && !waitrequest && address == `PDCAP_REG_CTRL && byteenable[0];
  endsequence

  sequence s_ask(logic [2:0] idx);
    descReq && descIdx == idx;
  endsequence

  sequence s_bus_wait;
    (read || write) && waitrequest;
  endsequence

  sequence s_attr_read;
    read && !waitrequest && address == `PDCAP_REG_ATTR;
  endsequence

  sequence s_ctrl_read;
    read && !waitrequest && address == `PDCAP_REG_CTRL;
  endsequence

  sequence s_served_read;
    read && !waitrequest && address == `PDCAP_REG_SERVED;
  endsequence

  a_type_byte_out: assert property (@(posedge mclk) disable iff (rst) // [R1]
    s_ask(`PDCAP_IDX_TYPE) |=> descValid && descByte == DESC_TYPE)
    else $error("descriptor type byte wrong");

  a_rsvd_byte_zero: assert property (@(posedge mclk) disable iff (rst) // [R2]
    s_ask(`PDCAP_IDX_RSVD) |=> descValid && descByte == 8'h00)
    else $error("reserved byte not zero");

  a_attr_reg_match: assert property (@(posedge mclk) disable iff (rst) // [R3]
    read && waitrequest && address == `PDCAP_REG_ATTR |=>
      !waitrequest && readdata == {25'h0000000, $past(stateQ.features), 1'b0})
    else $error("attribute register disagrees with features");

  a_bit0_reserved: assert property (@(posedge mclk) disable iff (rst) // [R4]
    s_ask(`PDCAP_IDX_ATTR0) |=> descByte[`PDCAP_BIT_RSVD0] == 1'b0)
    else $error("attribute bit 0 set");

  a_batchg_follows: assert property (@(posedge mclk) disable iff (rst) // [R5]
    s_ctrl_write |=>
      attrWord[`PDCAP_BIT_BATCHG] == $past(writedata[`PDCAP_BIT_BATCHG]))
    else $error("battery charging bit not as written");

  a_pd_follows: assert property (@(posedge mclk) disable iff (rst) // [R6]
    s_ctrl_write |=> attrWord[`PDCAP_BIT_PD] == $past(writedata[`PDCAP_BIT_PD]))
    else $error("power delivery bit not as written");

  a_provider_follows: assert property (@(posedge mclk) disable iff (rst) // [R7]
    s_ctrl_write |=> attrWord[`PDCAP_BIT_PROVIDER] == $past(writedata[`PDCAP_BIT_PROVIDER]))
    else $error("provider bit not as written");

  a_consumer_follows: assert property (@(posedge mclk) disable iff (rst) // [R8]
    s_ctrl_write |=> attrWord[`PDCAP_BIT_CONSUMER] == $past(writedata[`PDCAP_BIT_CONSUMER]))
    else $error("consumer bit not as written");

  a_chgpol_alone: assert property (@(posedge mclk) disable iff (rst) // [R9]
    s_ctrl_write ##0 (writedata[6:1] == 6'h10) |=> attrWord[7:0] == 8'h20)
    else $error("charging policy bit not independent");

  a_typec_follows: assert property (@(posedge mclk) disable iff (rst) // [R10]
    s_ctrl_write |=> attrWord[`PDCAP_BIT_TYPEC] == $past(writedata[`PDCAP_BIT_TYPEC]))
    else $error("type-c current bit not as written");

  a_cap_code_out: assert property (@(posedge mclk) disable iff (rst) // [R11]
    s_ask(`PDCAP_IDX_CAPTYPE) |=> descValid && descByte == `PDCAP_CAP_CODE)
    else $error("capability code byte wrong");

  a_upper_rsvd_zero: assert property (@(posedge mclk) disable iff (rst) // [R12]
    s_ask(`PDCAP_IDX_ATTR0) or s_ask(`PDCAP_IDX_ATTR3) |=>
      descByte[7] == 1'b0 && ($past(descIdx) != `PDCAP_IDX_ATTR3 || descByte == 8'h00))
    else $error("reserved attribute bits set");

  a_lsb_first: assert property (@(posedge mclk) disable iff (rst) // [R13]
    s_ask(`PDCAP_IDX_ATTR0) |=> descByte == $past(attrWord[7:0]))
    else $error("attribute byte order wrong");

  // the remaining bytes of the bitmap, each against its own slice
  a_attr1_order: assert property (@(posedge mclk) disable iff (rst) // [R13]
    s_ask(`PDCAP_IDX_ATTR1) |=> descValid && descByte == $past(attrWord[15:8]))
    else $error("attribute byte 1 wrong");

  a_attr2_order: assert property (@(posedge mclk) disable iff (rst) // [R13]
    s_ask(`PDCAP_IDX_ATTR2) |=> descValid && descByte == $past(attrWord[23:16]))
    else $error("attribute byte 2 wrong");

  a_attr3_order: assert property (@(posedge mclk) disable iff (rst) // [R13]
    s_ask(`PDCAP_IDX_ATTR3) |=> descValid && descByte == $past(attrWord[31:24]))
    else $error("attribute byte 3 wrong");

  a_length_byte_out: assert property (@(posedge mclk) disable iff (rst) // [R13]
    s_ask(`PDCAP_IDX_LENGTH) |=> descValid && descByte == `PDCAP_LENGTH)
    else $error("length byte wrong");

  a_byte_follows_ask: assert property (@(posedge mclk) disable iff (rst) // [R13]
    descReq |=> descValid)
    else $error("descriptor byte not delivered");

  a_valid_one_pulse: assert property (@(posedge mclk) disable iff (rst) // [R13]
    descValid |-> $past(descReq))
    else $error("descriptor valid without a request");

  // a held byte must not drift while the host looks elsewhere
  a_byte_holds: assert property (@(posedge mclk) disable iff (rst) // [R13]
    !descReq |=> $stable(descByte))
    else $error("descriptor byte changed without a request");

  a_served_counts: assert property (@(posedge mclk) disable iff (rst)
    descReq |=> stateQ.served == $past(stateQ.served) + 16'h0001)
    else $error("served count missed a byte");

  a_served_idle: assert property (@(posedge mclk) disable iff (rst)
    !descReq |=> $stable(stateQ.served))
    else $error("served count moved without a request");

  a_served_upper_zero: assert property (@(posedge mclk) disable iff (rst)
    s_served_read |-> readdata[31:16] == 16'h0000)
    else $error("served register upper half not zero");

  a_attr_read_fields: assert property (@(posedge mclk) disable iff (rst) // [R4]
    s_attr_read |-> readdata[`PDCAP_BIT_RSVD0] == 1'b0 && readdata[31:7] == 25'h0)
    else $error("attribute register reserved bits set");

  a_ctrl_read_fields: assert property (@(posedge mclk) disable iff (rst) // [R4]
    s_ctrl_read |-> readdata[`PDCAP_BIT_RSVD0] == 1'b0 && readdata[31:7] == 25'h0)
    else $error("control register reserved bits set");

  a_ctrl_read_back: assert property (@(posedge mclk) disable iff (rst) // [R3]
    s_ctrl_read |-> readdata[`PDCAP_FEAT_HI:`PDCAP_FEAT_LO] == $past(stateQ.features))
    else $error("control register does not read back");

  a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
    read && !waitrequest && address != `PDCAP_REG_CTRL && address != `PDCAP_REG_ATTR &&
      address != `PDCAP_REG_SERVED |-> readdata == `PDCAP_WORD_ZERO)
    else $error("unmapped address read not zero");

  a_attr_write_ignored: assert property (@(posedge mclk) disable iff (rst) // [R3]
    write && !waitrequest && address != `PDCAP_REG_CTRL |=> $stable(attrWord))
    else $error("bitmap changed by a write elsewhere");

  a_feat_hold: assert property (@(posedge mclk) disable iff (rst) // [R3]
    !(write && !waitrequest && address == `PDCAP_REG_CTRL && byteenable[0]) |=>
      $stable(attrWord))
    else $error("bitmap changed without a control write");

  a_ctrl_write_lands: assert property (@(posedge mclk) disable iff (rst) // [R3]
    s_ctrl_write |=> attrWord[`PDCAP_FEAT_HI:`PDCAP_FEAT_LO] ==
      $past(writedata[`PDCAP_FEAT_HI:`PDCAP_FEAT_LO]))
    else $error("feature bits not as written");

  a_chgpol_follows: assert property (@(posedge mclk) disable iff (rst) // [R9]
    s_ctrl_write |=> attrWord[`PDCAP_BIT_CHGPOL] == $past(writedata[`PDCAP_BIT_CHGPOL]))
    else $error("charging policy bit not as written");

  // roles are kept even without power delivery; ignoring them is the host's job
  a_roles_without_pd: assert property (@(posedge mclk) disable iff (rst) // [R7] [R8]
    s_ctrl_write ##0 !writedata[`PDCAP_BIT_PD] |=>
      attrWord[`PDCAP_BIT_CONSUMER:`PDCAP_BIT_PROVIDER] ==
        $past(writedata[`PDCAP_BIT_CONSUMER:`PDCAP_BIT_PROVIDER]))
    else $error("role bits lost without power delivery");

  a_one_wait: assert property (@(posedge mclk) disable iff (rst)
    s_bus_wait ##1 (read || write) |-> !waitrequest)
    else $error("access not granted after one wait cycle");

  a_new_access_waits: assert property (@(posedge mclk) disable iff (rst)
    $rose(read) || $rose(write) |-> waitrequest)
    else $error("new access answered without a wait cycle");

  a_idle_no_wait: assert property (@(posedge mclk) disable iff (rst)
    !(read || write) |-> !waitrequest)
    else $error("wait raised with no access");

  // the word must stand after the answer so a slow master can still take it
  a_readdata_stands: assert property (@(posedge mclk) disable iff (rst)
    !((read || write) && waitrequest) |=> $stable(readdata))
    else $error("read data moved outside an access");

endmodule // pdcap_descriptor

// File: hdl/pdcap_params.svh
`ifndef PDCAP_PARAMS_SVH
`define PDCAP_PARAMS_SVH

// register byte offsets
`define PDCAP_REG_CTRL      4'h0
`define PDCAP_REG_ATTR      4'h4
`define PDCAP_REG_SERVED    4'h8

// descriptor byte positions
`define PDCAP_IDX_LENGTH    3'h0
`define PDCAP_IDX_TYPE      3'h1
`define PDCAP_IDX_CAPTYPE   3'h2
`define PDCAP_IDX_RSVD      3'h3
`define PDCAP_IDX_ATTR0     3'h4
`define PDCAP_IDX_ATTR1     3'h5
`define PDCAP_IDX_ATTR2     3'h6
`define PDCAP_IDX_ATTR3     3'h7

// descriptor constants
`define PDCAP_LENGTH        8'h08
`define PDCAP_CAP_CODE      8'h06
`define PDCAP_RSVD_BYTE     8'h00

// attribute bit positions
`define PDCAP_BIT_RSVD0     0
`define PDCAP_BIT_BATCHG    1
`define PDCAP_BIT_PD        2
`define PDCAP_BIT_PROVIDER  3
`define PDCAP_BIT_CONSUMER  4
`define PDCAP_BIT_CHGPOL    5
`define PDCAP_BIT_TYPEC     6
`define PDCAP_FEAT_LO       1
`define PDCAP_FEAT_HI       6

// reset values
`define PDCAP_CTRL_RST      6'h00
`define PDCAP_SERVED_RST    16'h0000
`define PDCAP_BYTE_RST      8'h00
`define PDCAP_WORD_ZERO     32'h0000_0000

`endif

// File: hdl/pdcap_pkg.sv
package pdcap_pkg;

  typedef enum logic [0:0] {
    PDCAP_IDLE = 1'b0,
    PDCAP_ACK  = 1'b1
  } pdcap_bus_t;

  typedef struct packed {
    pdcap_bus_t  busState;
    logic [31:0] readData;
    logic [6:1]  features;
    logic [7:0]  descByte;
    logic        descValid;
    logic [15:0] served;
  } pdcap_state_t;

endpackage

// File: tb/pdcap_host_model.sv
`timescale 1ns/1ps
module pdcap_host_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reqEn,
  input  wire logic [2:0] reqIdx,
  input  wire logic [7:0] descByte,
  output logic            descReq,
  output logic      [2:0] descIdx,
  output logic      [1:0] roleSeen
);
  // index wanders while idle so a stale index never passes for a request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      descReq <= 1'b0;
      descIdx <= 3'h0;
    end else begin
      descReq <= reqEn;
      descIdx <= reqEn ? reqIdx : descIdx + 3'h3;
    end
  end
  // roles count only when the power delivery bit is set
  assign roleSeen = descByte[2] ? descByte[4:3] : 2'b00;
endmodule // pdcap_host_model

// File: tb/test_pd_capability_descriptor.sv
`timescale 1ns/1ps
module test_pd_capability_descriptor;
  logic mclk = 0, rst = 1, read = 0, write = 0, descValid, waitrequest, descReq, reqEn = 0;
  logic [3:0] address = 4'h0, byteenable = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, s, a, expWord;
  logic [1:0] roleSeen;
  logic [2:0] descIdx, reqIdx = 3'h0;
  logic [7:0] descByte;
  logic [31:0] expQ[$];
  logic [7:0] descQ[$];
  int mismatches = 0, n_tests = 0, cyc = 0, srv = 0;
  initial forever #5 mclk = ~mclk;
  pdcap_descriptor i_dut (.mclk(mclk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .descReq(descReq), .descIdx(descIdx),
    .descByte(descByte), .descValid(descValid));
  pdcap_host_model i_host (.mclk(mclk), .rst(rst), .reqEn(reqEn), .reqIdx(reqIdx),
    .descByte(descByte), .descReq(descReq), .descIdx(descIdx), .roleSeen(roleSeen));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d);
    @(posedge mclk);
    address <= ad;
    writedata <= d;
    byteenable <= 4'hf;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    do @(posedge mclk); while (waitrequest);
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, ad, 32'h0);
  endtask
  task automatic descAll(input logic [31:0] at);
    logic [63:0] v;
    v = {at, 8'h00, 8'h06, 8'h10, 8'h08};
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      reqEn <= 1'b1;
      reqIdx <= i[2:0];
      descQ.push_back(v[i*8 +: 8]);
    end
    @(posedge mclk);
    reqEn <= 1'b0;
    srv = srv + 8;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  always @(posedge mclk) begin
    if (read && !waitrequest) begin
      expWord = expQ.pop_front();
      n_tests++;
      if (readdata !== expWord) begin
        mismatches++;
        $display("Error readdata exp %h got %h", expWord, readdata);
      end
    end
    if (descValid) begin
      n_tests++;
      if (descByte !== descQ[0]) begin
        mismatches++;
        $display("Error descByte exp %h got %h", descQ[0], descByte);
      end
      n_tests++;
      if (roleSeen !== (descQ[0][2] ? descQ[0][4:3] : 2'b00)) begin
        mismatches++;
        $display("Error roleSeen exp %h got %h", descQ[0][2] ? descQ[0][4:3] : 2'b00, roleSeen);
      end
      void'(descQ.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd(4'h4, 32'h0);
    s = 32'hc349fc89;
    for (int k = 0; k < 5; k++) begin
      s = nxt(s);
      if (k == 0) s = 32'hffff_ffff;
      if (k == 1) s = 32'h0000_0020;
      bus(1'b1, 4'h0, s);
      a = {25'h0, s[6:1], 1'b0};
      rd(4'h4, a);
      rd(4'h0, a);
      bus(1'b1, 4'h4, ~s);
      descAll(a);
      rd(4'h8, srv);
    end
    rd(4'hc, 32'h0);
    repeat (4) @(posedge mclk);
    report_and_stop();
  end
endmodule // test_pd_capability_descriptor
